// File: rtl/ssfrp_pkg.sv
package ssfrp_pkg;

  // Register offsets (8-bit map, 00h to 3Ah)
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h00;
  localparam logic [7:0] ADDR_TEMP_OUT     = 8'h01;
  localparam logic [7:0] ADDR_VECTOR_MAGNITUDE_OUT_LO      = 8'h02;
  localparam logic [7:0] ADDR_VECTOR_MAGNITUDE_OUT_HI      = 8'h03;
  localparam logic [7:0] ADDR_X_LO         = 8'h04;
  localparam logic [7:0] ADDR_X_HI         = 8'h05;
  localparam logic [7:0] ADDR_Y_LO         = 8'h06;
  localparam logic [7:0] ADDR_Y_HI         = 8'h07;
  localparam logic [7:0] ADDR_Z_LO         = 8'h08;
  localparam logic [7:0] ADDR_Z_HI         = 8'h09;
  localparam logic [7:0] ADDR_SYS_MODE     = 8'h14;
  localparam logic [7:0] ADDR_SENS_CFG_A   = 8'h15;
  localparam logic [7:0] ADDR_SENS_CFG_C   = 8'h17;
  localparam logic [7:0] ADDR_BUF_CFG      = 8'h1D;
  localparam logic [7:0] ADDR_IRQ_STICKY   = 8'h21;
  localparam logic [7:0] ADDR_IRQ_MASK     = 8'h22;
  localparam logic [7:0] ADDR_RSVD_A       = 8'h39;
  localparam logic [7:0] ADDR_RSVD_B       = 8'h3A;
  localparam logic [7:0] ADDR_WRAP_TO      = 8'h00;

  // Field positions
  localparam int CFG_A_ACTIVE_BIT   = 0;
  localparam int CFG_A_SOFT_RST_BIT = 7;
  localparam int CFG_C_BYTE_ORD_BIT = 0;
  localparam int CFG_C_TRIG_BIT     = 1;
  localparam int BUF_FLUSH_BIT      = 7;
  localparam int BUF_MODE_LO        = 5;
  localparam int STAT_NEW_BIT       = 7;
  localparam int STAT_OVR_BIT       = 6;
  localparam int STAT_BOOT_BIT      = 0;
  localparam int IRQ_NEW_BIT        = 0;
  localparam int IRQ_OVR_BIT        = 1;
  localparam int IRQ_REFUSED_BIT    = 2;

  // Reset values
  localparam logic [7:0] EVENT_STATUS_RST = 8'h01;
  localparam logic [7:0] RSVD_A_RST       = 8'h00;
  localparam logic [7:0] CFG_RST          = 8'h00;
  localparam logic [1:0] BUF_MODE_OFF     = 2'h0;
  localparam logic [7:0] RD_UNMAPPED      = 8'h00;

  // Timing: 20 MHz core clock, 5 ms interrupt pulse
  localparam int CLK_HZ            = 20_000_000;
  localparam int PULSE_WIDTH_US    = 5000;
  localparam int PULSE_WIDTH_CYC   = (CLK_HZ / 1_000_000) * PULSE_WIDTH_US;

  typedef enum logic [1:0] {
    SSFRP_STANDBY,
    SSFRP_ACTIVE,
    SSFRP_EXTERNAL_TRIGGER_MODE
  } ssfrp_mode_e;

  // One result set from the sensing core
  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
    logic [11:0] vector_magnitude_out;
    logic [7:0]  temp;
  } ssfrp_sample_s;

  // Host register request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       auto_inc;
  } ssfrp_req_s;

endpackage

// File: rtl/ssfrp_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Marked registers survive active to standby
// - Hibernate exit or reset wipes every register
// - Output group cleared on standby to running
// - Byte order bit picks LE-right or BE-left
// - Buffer marked stale on standby to running
// - Protected writes only in standby mode
// - Active bit frozen in external-trigger mode
// - Auto-increment 39h to 3Ah, wraps to 00h
// - New-sample flag set on fresh result set
// - Magnitude or axis register read clears new-sample flag
// - New-sample flag zero while buffer enabled
// - Strap low: read clears flag and interrupt
// - Strap high: interrupt is timed pulse
// - Entering standby cuts the pulse short
// - Overrun set when unread set is overwritten
// - No overrun if axis read since last set
// - Status read clears the overrun flag
// - Overrun flag zero while buffer enabled

module ssfrp_regs #(
  parameter int PULSE_CYCLES = ssfrp_pkg::PULSE_WIDTH_CYC
) (
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_n_i,
  input  wire ssfrp_pkg::ssfrp_req_s   req_i,
  output logic [7:0]                   rd_data_o,
  input  wire logic                    sample_valid_i,
  input  wire ssfrp_pkg::ssfrp_sample_s sample_i,
  input  wire logic                    hibernate_exit_i,
  input  wire logic                    boot_mode_strap_i,
  output ssfrp_pkg::ssfrp_mode_e       mode_o,
  output logic                         byte_order_select_o,
  output logic [1:0]                   buf_mode_o,
  output logic                         buf_flush_o,
  output logic                         buf_stale_o,
  output logic                         drdy_int_o,
  output logic                         irq_o
);

  // Counter below is 20 bits wide, so longer pulses cannot be served
  if (PULSE_CYCLES < 1 || PULSE_CYCLES > 2**20 - 1) begin : g_pulse_range
    $error("PULSE_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [7:0] next_addr(input logic [7:0] a);
    if (a >= ssfrp_pkg::ADDR_RSVD_B) begin
      next_addr = ssfrp_pkg::ADDR_WRAP_TO;
    end else begin
      next_addr = a + 8'h01;
    end
  endfunction

  // Low register of a 12-bit word, per byte order
  function automatic logic [7:0] lo_byte(input logic [11:0] d, input logic be);
    lo_byte = be ? d[11:4] : d[7:0];
  endfunction

  function automatic logic [7:0] hi_byte(input logic [11:0] d, input logic be);
    hi_byte = be ? {d[3:0], 4'h0} : {4'h0, d[11:8]};
  endfunction

  function automatic logic is_axis(input logic [7:0] a);
    is_axis = (a >= ssfrp_pkg::ADDR_X_LO) && (a <= ssfrp_pkg::ADDR_Z_HI);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0]            cfg_a;
  logic [7:0]            cfg_c;
  logic [7:0]            buf_cfg;
  logic [7:0]            rsvd_a;
  logic [7:0]            irq_sticky;
  logic [7:0]            irq_mask;
  logic [7:0]            auto_ptr;
  ssfrp_pkg::ssfrp_sample_s out_q;
  logic                  new_flag;
  logic                  ovr_flag;
  logic                  axis_read;
  logic                  soft_rst;
  logic                  strap;
  logic                  strap_taken;
  logic [19:0]           pulse_cnt;
  ssfrp_pkg::ssfrp_mode_e mode;
  ssfrp_pkg::ssfrp_mode_e prev_mode;

  logic       wipe;
  logic [7:0] acc_addr;
  logic       wr;
  logic       rd;
  logic       standby;
  logic       go_run;
  logic       buf_on;
  logic       out_read;
  logic       stat_read;
  logic       refused;
  logic       new_set;
  logic       ovr_set;
  logic [7:0] event_status;
  logic       order_be;

  // Full wipe on reset, hibernate exit or soft reset
  assign wipe      = !rst_n_i || hibernate_exit_i || soft_rst;
  // Auto-increment uses the internal pointer
  assign acc_addr  = req_i.auto_inc ? auto_ptr : req_i.addr;
  assign wr        = req_i.wr;
  assign rd        = req_i.rd;
  assign standby   = (mode == ssfrp_pkg::SSFRP_STANDBY);
  assign go_run    = (prev_mode == ssfrp_pkg::SSFRP_STANDBY) && !standby;
  assign buf_on    = (buf_cfg[ssfrp_pkg::BUF_MODE_LO +: 2] != ssfrp_pkg::BUF_MODE_OFF);
  assign out_read  = rd && (acc_addr >= ssfrp_pkg::ADDR_VECTOR_MAGNITUDE_OUT_LO)
                        && (acc_addr <= ssfrp_pkg::ADDR_Z_HI);
  assign stat_read = rd && (acc_addr == ssfrp_pkg::ADDR_EVENT_STATUS);
  assign order_be  = cfg_c[ssfrp_pkg::CFG_C_BYTE_ORD_BIT];
  assign new_set   = sample_valid_i && !standby && !buf_on;
  // Previous set still unread and no axis touched since it landed
  assign ovr_set   = new_set && new_flag && !axis_read;

  ////////////////////////////////////////////////////////////////////////
  // Operating mode from the control bits

  always_comb begin
    if (!cfg_a[ssfrp_pkg::CFG_A_ACTIVE_BIT]) begin
      mode = ssfrp_pkg::SSFRP_STANDBY;
    end else if (cfg_c[ssfrp_pkg::CFG_C_TRIG_BIT]) begin
      mode = ssfrp_pkg::SSFRP_EXTERNAL_TRIGGER_MODE;
    end else begin
      mode = ssfrp_pkg::SSFRP_ACTIVE;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (wipe) begin
      prev_mode <= ssfrp_pkg::SSFRP_STANDBY;
    end else begin
      prev_mode <= mode;
    end
  end

  // Boot strap caught once after reset release, not on wipe
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      strap       <= 1'b0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      strap       <= boot_mode_strap_i;
      strap_taken <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Host writes: protection and control registers

  // Refused: a Control C or reserved write outside standby
  always_comb begin
    refused = 1'b0;
    if (wr && !standby) begin
      case (acc_addr)
        ssfrp_pkg::ADDR_SENS_CFG_A: refused = 1'b0;
        ssfrp_pkg::ADDR_BUF_CFG:    refused = 1'b0;
        ssfrp_pkg::ADDR_SENS_CFG_C: refused = 1'b1;
        ssfrp_pkg::ADDR_RSVD_A:     refused = 1'b1;
        default:                    refused = 1'b0;
      endcase
    end
  end

  // Control A: soft reset open in every mode, active bit frozen in trigger mode
  always_ff @(posedge core_clk_i) begin
    if (wipe) begin
      cfg_a    <= ssfrp_pkg::CFG_RST;
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= 1'b0;
      if (wr && acc_addr == ssfrp_pkg::ADDR_SENS_CFG_A) begin
        soft_rst <= req_i.wdata[ssfrp_pkg::CFG_A_SOFT_RST_BIT];
        if (standby) begin
          cfg_a <= {1'b0, req_i.wdata[6:0]};
        end else if (mode == ssfrp_pkg::SSFRP_ACTIVE) begin
          cfg_a[ssfrp_pkg::CFG_A_ACTIVE_BIT] <=
            req_i.wdata[ssfrp_pkg::CFG_A_ACTIVE_BIT];
        end
        // External_trigger_mode: active bit left untouched
      end
    end
  end

  // Control C: byte order and trigger select, standby only
  always_ff @(posedge core_clk_i) begin
    if (wipe) begin
      cfg_c <= ssfrp_pkg::CFG_RST;
    end else if (wr && standby && acc_addr == ssfrp_pkg::ADDR_SENS_CFG_C) begin
      cfg_c <= req_i.wdata;
    end
  end

  // Buffer config: mode protected, flush open in every mode
  always_ff @(posedge core_clk_i) begin
    if (wipe) begin
      buf_cfg     <= ssfrp_pkg::CFG_RST;
      buf_flush_o <= 1'b0;
    end else begin
      buf_flush_o <= 1'b0;
      if (wr && acc_addr == ssfrp_pkg::ADDR_BUF_CFG) begin
        buf_flush_o <= req_i.wdata[ssfrp_pkg::BUF_FLUSH_BIT];
        if (standby) begin
          buf_cfg <= {1'b0, req_i.wdata[6:0]};
        end
      end
    end
  end

  // Factory reserved; storage kept only so reads are stable
  always_ff @(posedge core_clk_i) begin
    if (wipe) begin
      rsvd_a <= ssfrp_pkg::RSVD_A_RST;
    end else if (wr && standby && acc_addr == ssfrp_pkg::ADDR_RSVD_A) begin
      rsvd_a <= req_i.wdata;
    end
  end

  // Auto-increment pointer follows every access
  always_ff @(posedge core_clk_i) begin
    if (wipe) begin
      auto_ptr <= ssfrp_pkg::ADDR_WRAP_TO;
    end else if (wr || rd) begin
      auto_ptr <= next_addr(acc_addr);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output data registers

  // Nothing here reacts to active-to-standby, so contents stay
  always_ff @(posedge core_clk_i) begin
    if (wipe || go_run) begin
      out_q <= '0;
    end else if (sample_valid_i && !standby) begin
      out_q <= sample_i;
    end
  end

  // Stale-buffer pulse on the move out of standby
  always_ff @(posedge core_clk_i) begin
    if (wipe) begin
      buf_stale_o <= 1'b0;
    end else begin
      buf_stale_o <= go_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags; a set in a read-clear cycle wins

  always_ff @(posedge core_clk_i) begin
    if (wipe || go_run || buf_on) begin
      new_flag <= 1'b0;
    end else if (new_set) begin
      new_flag <= 1'b1;
    end else if (out_read) begin
      new_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (wipe || go_run || buf_on) begin
      ovr_flag <= 1'b0;
    end else if (ovr_set) begin
      ovr_flag <= 1'b1;
    end else if (stat_read) begin
      ovr_flag <= 1'b0;
    end
  end

  // Any axis read since the last set landed
  always_ff @(posedge core_clk_i) begin
    if (wipe || go_run) begin
      axis_read <= 1'b0;
    end else if (new_set) begin
      axis_read <= 1'b0;
    end else if (rd && is_axis(acc_addr)) begin
      axis_read <= 1'b1;
    end
  end

  // Read-only view; boot bit fixed high after reset
  always_comb begin
    event_status = ssfrp_pkg::EVENT_STATUS_RST;
    event_status[ssfrp_pkg::STAT_NEW_BIT] = new_flag && !buf_on;
    event_status[ssfrp_pkg::STAT_OVR_BIT] = ovr_flag && !buf_on;
    event_status[ssfrp_pkg::STAT_BOOT_BIT] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Data-ready interrupt pin

  // Strap high: timed pulse, cut short by standby
  always_ff @(posedge core_clk_i) begin
    if (wipe || standby) begin
      pulse_cnt <= '0;
    end else if (strap && new_set) begin
      pulse_cnt <= 20'(PULSE_CYCLES);
    end else if (pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - 20'h00001;
    end
  end

  // Strap low follows the flag, so a read drops it too
  always_ff @(posedge core_clk_i) begin
    if (wipe) begin
      drdy_int_o <= 1'b0;
    end else if (strap) begin
      // Standby gates the pin too, else it lags the cut by a cycle
      drdy_int_o <= !standby && ((pulse_cnt > 20'h00001) || new_set);
    end else begin
      // Next value of the flag, except a set in the go_run cycle, which raises the pin alone
      drdy_int_o <= new_set || (new_flag && !out_read && !go_run && !buf_on);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky event register, write one to clear

  always_ff @(posedge core_clk_i) begin
    if (wipe) begin
      irq_sticky <= 8'h00;
      irq_mask   <= 8'h00;
    end else begin
      if (wr && acc_addr == ssfrp_pkg::ADDR_IRQ_MASK) begin
        irq_mask <= req_i.wdata;
      end
      irq_sticky <= (irq_sticky
                     & ~((wr && acc_addr == ssfrp_pkg::ADDR_IRQ_STICKY)
                         ? req_i.wdata : 8'h00))
                    | {5'h00, refused, ovr_set, new_set};
    end
  end

  assign irq_o = |(irq_sticky & irq_mask);

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe

  always_ff @(posedge core_clk_i) begin
    if (wipe) begin
      rd_data_o <= 8'h00;
    end else if (rd) begin
      case (acc_addr)
        ssfrp_pkg::ADDR_EVENT_STATUS: rd_data_o <= event_status;
        ssfrp_pkg::ADDR_TEMP_OUT:     rd_data_o <= out_q.temp;
        ssfrp_pkg::ADDR_VECTOR_MAGNITUDE_OUT_LO:      rd_data_o <= lo_byte(out_q.vector_magnitude_out, order_be);
        ssfrp_pkg::ADDR_VECTOR_MAGNITUDE_OUT_HI:      rd_data_o <= hi_byte(out_q.vector_magnitude_out, order_be);
        ssfrp_pkg::ADDR_X_LO:         rd_data_o <= lo_byte(out_q.x, order_be);
        ssfrp_pkg::ADDR_X_HI:         rd_data_o <= hi_byte(out_q.x, order_be);
        ssfrp_pkg::ADDR_Y_LO:         rd_data_o <= lo_byte(out_q.y, order_be);
        ssfrp_pkg::ADDR_Y_HI:         rd_data_o <= hi_byte(out_q.y, order_be);
        ssfrp_pkg::ADDR_Z_LO:         rd_data_o <= lo_byte(out_q.z, order_be);
        ssfrp_pkg::ADDR_Z_HI:         rd_data_o <= hi_byte(out_q.z, order_be);
        ssfrp_pkg::ADDR_SYS_MODE:     rd_data_o <= {6'h00, mode};
        ssfrp_pkg::ADDR_SENS_CFG_A:   rd_data_o <= cfg_a;
        ssfrp_pkg::ADDR_SENS_CFG_C:   rd_data_o <= cfg_c;
        ssfrp_pkg::ADDR_BUF_CFG:      rd_data_o <= buf_cfg;
        ssfrp_pkg::ADDR_IRQ_STICKY:   rd_data_o <= irq_sticky;
        ssfrp_pkg::ADDR_IRQ_MASK:     rd_data_o <= irq_mask;
        ssfrp_pkg::ADDR_RSVD_A:       rd_data_o <= rsvd_a;
        default:                      rd_data_o <= ssfrp_pkg::RD_UNMAPPED;
      endcase
    end
  end

  assign mode_o              = mode;
  assign byte_order_select_o = order_be;
  assign buf_mode_o          = buf_cfg[ssfrp_pkg::BUF_MODE_LO +: 2];

endmodule
`default_nettype wire

// File: tb/ssfrp_host.sv
`timescale 1ns/1ps
`default_nettype none
module ssfrp_host (
  input  wire logic                   core_clk_i,
  input  wire logic [7:0]             rd_data_i,
  output var ssfrp_pkg::ssfrp_req_s   req_o
);
  initial req_o = '0;

  // One access; read data is taken in the cycle after the strobe
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic ai, output logic [7:0] q);
    q = 8'h00;
    if (w && !ai && a == ssfrp_pkg::ADDR_RSVD_A) return;
    @(posedge core_clk_i);
    req_o <= '{addr: a, wdata: d, wr: w, rd: !w, auto_inc: ai};
    @(posedge core_clk_i);
    // Idle lines scrambled so nothing leans on stale values
    req_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0, auto_inc: ~ai};
    if (!w) begin
      @(posedge core_clk_i);
      q = rd_data_i;
    end
  endtask
endmodule
`default_nettype wire

// File: tb/ssfrp_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ssfrp_regs_chk #(
  parameter int PULSE_CYCLES = 8
) (
  input wire logic                     core_clk_i,
  input wire logic                     rst_n_i,
  input wire ssfrp_pkg::ssfrp_req_s    req_i,
  input wire logic [7:0]               rd_data_o,
  input wire logic                     sample_valid_i,
  input wire ssfrp_pkg::ssfrp_sample_s sample_i,
  input wire logic                     hibernate_exit_i,
  input wire logic                     boot_mode_strap_i,
  input wire ssfrp_pkg::ssfrp_mode_e   mode_o,
  input wire logic                     byte_order_select_o,
  input wire logic [1:0]               buf_mode_o,
  input wire logic                     buf_flush_o,
  input wire logic                     buf_stale_o,
  input wire logic                     drdy_int_o,
  input wire logic                     irq_o
);
  logic        seen;
  logic        strap_q;
  logic [31:0] hi_cnt;
  wire logic   stby = (mode_o == ssfrp_pkg::SSFRP_STANDBY);
  wire logic   rd_out = req_i.rd && !req_i.auto_inc && req_i.addr inside {[8'h02:8'h09]};

  // Plain-address strobes; pointer accesses are left out on purpose
  function automatic logic rd_at(input logic [7:0] a);
    return req_i.rd && !req_i.auto_inc && req_i.addr == a;
  endfunction
  function automatic logic wr_at(input logic [7:0] a);
    return req_i.wr && !req_i.auto_inc && req_i.addr == a;
  endfunction

  // Strap copy and length of the current interrupt pulse
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      seen <= 1'b0;
      strap_q <= 1'b0;
      hi_cnt <= 32'h0;
    end else begin
      if (!seen) strap_q <= boot_mode_strap_i;
      seen <= 1'b1;
      hi_cnt <= drdy_int_o ? hi_cnt + 32'h1 : 32'h0;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_leave;
    stby ##1 !stby;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  reset_clean_a: assert property ($rose(rst_n_i)
    |-> stby && !byte_order_select_o && !drdy_int_o)
    else $error("outputs not cleared by reset");
  boot_bit_a: assert property (rd_at(8'h00) |=> rd_data_o[5:0] == 6'h01)
    else $error("status low bits wrong");
  wrap_top_a: assert property (rd_at(8'h3A) |=> rd_data_o == 8'h00)
    else $error("top reserved read not zero");
  stale_pulse_a: assert property (s_leave |=> buf_stale_o)
    else $error("no stale pulse on leaving standby");
  flush_pulse_a: assert property (wr_at(8'h1D) && req_i.wdata[7] |=> buf_flush_o)
    else $error("flush write gave no pulse");
  cfg_locked_a: assert property (!stby && wr_at(8'h17) && !hibernate_exit_i
    |=> $stable(byte_order_select_o))
    else $error("protected write took effect");
  active_frozen_a: assert property (mode_o == ssfrp_pkg::SSFRP_EXTERNAL_TRIGGER_MODE && wr_at(8'h15)
    && !req_i.wdata[7] && !hibernate_exit_i |=> mode_o == ssfrp_pkg::SSFRP_EXTERNAL_TRIGGER_MODE)
    else $error("mode changed in trigger mode");
  drdy_set_a: assert property (seen && sample_valid_i && !stby && buf_mode_o == 2'h0
    && !hibernate_exit_i |=> drdy_int_o)
    else $error("no data-ready after sample");
  read_clear_a: assert property (seen && !strap_q && rd_out && !sample_valid_i
    |=> !drdy_int_o)
    else $error("output read left interrupt up");
  pulse_len_a: assert property (seen && strap_q && $fell(drdy_int_o) && !stby
    |-> hi_cnt == PULSE_CYCLES)
    else $error("interrupt pulse length wrong");
  pulse_cut_a: assert property (seen && strap_q && stby && $past(stby) |-> !drdy_int_o)
    else $error("pulse survived standby");
  buf_hold_a: assert property (buf_mode_o != 2'h0 && rd_at(8'h00)
    |=> rd_data_o[7:6] == 2'h0)
    else $error("flags set with buffer on");
endmodule
bind ssfrp_regs ssfrp_regs_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .rd_data_o(rd_data_o),
  .sample_valid_i(sample_valid_i), .sample_i(sample_i), .hibernate_exit_i(hibernate_exit_i),
  .boot_mode_strap_i(boot_mode_strap_i), .mode_o(mode_o),
  .byte_order_select_o(byte_order_select_o), .buf_mode_o(buf_mode_o),
  .buf_flush_o(buf_flush_o), .buf_stale_o(buf_stale_o), .drdy_int_o(drdy_int_o),
  .irq_o(irq_o));
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int PULSE = 8;
  logic                     core_clk_i, rst_n_i, sample_valid_i, hibernate_exit_i;
  logic                     boot_mode_strap_i, byte_order_select_o, buf_flush_o;
  logic                     buf_stale_o, drdy_int_o, irq_o;
  logic [7:0]               rd_data_o;
  logic [1:0]               buf_mode_o;
  ssfrp_pkg::ssfrp_req_s    req_i;
  ssfrp_pkg::ssfrp_sample_s sample_i;
  ssfrp_pkg::ssfrp_mode_e   mode_o;
  int                       num_errors, check_count, n;

  ssfrp_regs #(.PULSE_CYCLES(PULSE)) dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .rd_data_o(rd_data_o),
    .sample_valid_i(sample_valid_i), .sample_i(sample_i), .hibernate_exit_i(hibernate_exit_i),
    .boot_mode_strap_i(boot_mode_strap_i), .mode_o(mode_o),
    .byte_order_select_o(byte_order_select_o), .buf_mode_o(buf_mode_o),
    .buf_flush_o(buf_flush_o), .buf_stale_o(buf_stale_o), .drdy_int_o(drdy_int_o),
    .irq_o(irq_o));
  ssfrp_host host (.core_clk_i(core_clk_i), .rd_data_i(rd_data_o), .req_o(req_i));

  // Free-running core clock
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Accesses end 1 ns past the edge so port checks see settled values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.acc(1'b1, a, d, 1'b0, q);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic ai = 1'b0);
    logic [7:0] q;
    host.acc(1'b0, a, 8'h00, ai, q);
    #1;
    chk(q, e);
  endtask
  task automatic smp(input logic [11:0] x);
    @(posedge core_clk_i);
    sample_valid_i <= 1'b1;
    sample_i <= '{x: x, default: '0};
    @(posedge core_clk_i);
    sample_valid_i <= 1'b0;
    #1;
  endtask
  task automatic do_reset(input logic strap);
    rst_n_i <= 1'b0;
    boot_mode_strap_i <= strap;
    repeat (6) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
  endtask
  task automatic wrap_up;
    $display("Checks: %0d, errors: %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Hang guard, well past the longest sequence
  initial begin
    #2000000;
    num_errors++;
    wrap_up();
  end

  // Main sequence
  initial begin
    num_errors = 0;
    check_count = 0;
    rst_n_i = 1'b0;
    sample_valid_i = 1'b0;
    hibernate_exit_i = 1'b0;
    boot_mode_strap_i = 1'b0;
    sample_i = '0;
    do_reset(1'b0);
    rd(8'h00, 8'h01);
    chk({7'h0, byte_order_select_o}, 8'h00);
    wr(8'h17, 8'h01);
    wr(8'h15, 8'h01);
    chk({6'h0, mode_o}, 8'h01);
    smp(12'hABC);
    rd(8'h00, 8'h81);
    chk({7'h0, drdy_int_o}, 8'h01);
    rd(8'h04, 8'hAB);
    chk({7'h0, drdy_int_o}, 8'h00);
    rd(8'h05, 8'hC0);
    rd(8'h00, 8'h01);
    smp(12'h123);
    smp(12'h456);
    rd(8'h00, 8'hC1);
    rd(8'h00, 8'h81);
    rd(8'h04, 8'h45);
    smp(12'h789);
    rd(8'h00, 8'h81);
    // Refused write, then sticky, mask and clear of the interrupt
    wr(8'h17, 8'h00);
    chk({7'h0, byte_order_select_o}, 8'h01);
    rd(8'h21, 8'h07);
    chk({7'h0, irq_o}, 8'h00);
    wr(8'h22, 8'h04);
    chk({7'h0, irq_o}, 8'h01);
    wr(8'h21, 8'h07);
    chk({7'h0, irq_o}, 8'h00);
    rd(8'h21, 8'h00);
    wr(8'h15, 8'h00);
    chk({6'h0, mode_o}, 8'h00);
    rd(8'h04, 8'h78);
    wr(8'h1D, 8'h20);
    wr(8'h15, 8'h01);
    rd(8'h04, 8'h00);
    smp(12'h111);
    smp(12'h222);
    rd(8'h00, 8'h01);
    wr(8'h1D, 8'h80);
    chk({7'h0, buf_flush_o}, 8'h01);
    chk({6'h0, buf_mode_o}, 8'h01);
    // Trigger mode: active bit frozen, then hibernate exit wipes
    wr(8'h15, 8'h00);
    wr(8'h1D, 8'h00);
    wr(8'h17, 8'h03);
    wr(8'h15, 8'h01);
    wr(8'h15, 8'h00);
    chk({6'h0, mode_o}, 8'h02);
    @(posedge core_clk_i);
    hibernate_exit_i <= 1'b1;
    @(posedge core_clk_i);
    hibernate_exit_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    chk({5'h0, mode_o, byte_order_select_o}, 8'h00);
    rd(8'h39, 8'h00);
    rd(8'h30, 8'h00, 1'b1);
    rd(8'h30, 8'h01, 1'b1);
    rd(8'h30, 8'h00);
    // Strap high: timed pulse, little-endian layout, cut by standby
    do_reset(1'b1);
    wr(8'h15, 8'h01);
    smp(12'hABC);
    n = 0;
    // Sampled 1 ns past each edge, starting in the cycle the pulse rises
    repeat (20) begin
      if (drdy_int_o === 1'b1) n++;
      @(posedge core_clk_i);
      #1;
    end
    chk(8'(n), 8'(PULSE));
    rd(8'h00, 8'h81);
    rd(8'h04, 8'hBC);
    rd(8'h05, 8'h0A);
    rd(8'h00, 8'h01);
    smp(12'h001);
    wr(8'h15, 8'h00);
    @(posedge core_clk_i);
    #1;
    chk({7'h0, drdy_int_o}, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
